// file: design/gxp_expander.sv
// Purpose: Eight-bit port expander with an I2C slave and change interrupt.
// Assumes: SCL and SDA are sampled on i_clk, far faster than the bus.
// Notes: i_rst_b stands for the internal power-on reset.
`timescale 1ns/1ps
`include "gxp_regs.svh"
module gxp_expander
    import gxp_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Address select pins.
    input wire logic i_addr_sel_bit0,
    input wire logic i_addr_sel_bit1,
    input wire logic i_addr_sel_bit2,
    // Serial bus.
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // Port pins.
    input wire logic [7:0] i_port_pins,
    output logic [7:0] o_port_pins,
    output logic [7:0] o_port_pins_oe,
    // Open-drain interrupt, active low.
    output logic o_irq_b,
    output logic o_irq_oe
);

    // ------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_b_r;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r <= rst_s1_r;
        end
    end

    logic [12:0] in_s1_r;
    logic [12:0] in_s2_r;
    logic scl_prev_r;
    logic sda_prev_r;
    always_ff @(posedge i_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            in_s1_r <= 13'h1FFF;
            in_s2_r <= 13'h1FFF;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            in_s1_r <= {i_addr_sel_bit2, i_addr_sel_bit1, i_addr_sel_bit0,
                        i_scl, i_sda, i_port_pins};
            in_s2_r <= in_s1_r;
            scl_prev_r <= in_s2_r[9];
            sda_prev_r <= in_s2_r[8];
        end
    end

    logic [7:0] pins;
    logic [2:0] asel;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign pins = in_s2_r[7:0];
    assign sda = in_s2_r[8];
    assign scl = in_s2_r[9];
    assign asel = in_s2_r[12:10];
    assign scl_rise = scl & ~scl_prev_r;
    assign scl_fall = ~scl & scl_prev_r;
    assign start_cond = scl & scl_prev_r & sda_prev_r & ~sda;
    assign stop_cond = scl & scl_prev_r & ~sda_prev_r & sda;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] out_r;
    logic [7:0] pol_r;
    logic [7:0] dir_r;
    logic [7:0] in_cap_r;
    logic [1:0] ptr_r;
    logic ptr_valid_r;
    // Polarity-applied pin levels, read by the machine and the capture.
    logic [7:0] in_cap_nxt;

    function automatic logic [7:0] reg_read(input logic [1:0] sel,
                                            input logic [7:0] inp);
        case (sel)
            `GXP_CMD_INPUT: reg_read = inp;
            `GXP_CMD_OUTPUT: reg_read = out_r;
            `GXP_CMD_POLARITY: reg_read = pol_r;
            default: reg_read = dir_r;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Serial slave machine
    // ------------------------------------------------------------
    gxp_state_t state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic rd_mode_r;
    logic got_cmd_r;
    logic ack_drive_r;
    logic clr_pulse_r;
    logic [7:0] tx_r;

    logic addr_match;
    assign addr_match = (shift_r[7:4] == {1'b0, 3'h7}) &&
                        (shift_r[3:1] == asel);

    always_ff @(posedge i_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            state_r <= GXP_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            rd_mode_r <= 1'b0;
            got_cmd_r <= 1'b0;
            ack_drive_r <= 1'b0;
            clr_pulse_r <= 1'b0;
            tx_r <= 8'h00;
            ptr_r <= `GXP_CMD_INPUT;
            ptr_valid_r <= 1'b0;
            out_r <= `GXP_RST_OUTPUT;
            pol_r <= `GXP_RST_POLARITY;
            dir_r <= `GXP_RST_DIRECTION;
        end else begin
            clr_pulse_r <= 1'b0;
            if (stop_cond) begin
                state_r <= GXP_IDLE;
                ack_drive_r <= 1'b0;
            end else if (start_cond) begin
                state_r <= GXP_ADDR;
                bit_cnt_r <= 4'h0;
                ack_drive_r <= 1'b0;
            end else begin
                case (state_r)
                    GXP_IDLE: begin
                        ack_drive_r <= 1'b0;
                    end
                    GXP_ADDR, GXP_WRB: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == GXP_ADDR) begin
                                // A foreign address leaves us idle.
                                if (addr_match && (!shift_r[0] ||
                                        ptr_valid_r)) begin
                                    ack_drive_r <= 1'b1;
                                    rd_mode_r <= shift_r[0];
                                    got_cmd_r <= 1'b0;
                                    state_r <= GXP_ACK;
                                end else begin
                                    state_r <= GXP_IDLE;
                                end
                            end else begin
                                ack_drive_r <= 1'b1;
                                state_r <= GXP_ACK;
                                if (!got_cmd_r) begin
                                    ptr_r <= shift_r[1:0];
                                    ptr_valid_r <= 1'b1;
                                    got_cmd_r <= 1'b1;
                                end else begin
                                    case (ptr_r)
                                        `GXP_CMD_OUTPUT: out_r <= shift_r;
                                        `GXP_CMD_POLARITY: pol_r <= shift_r;
                                        `GXP_CMD_DIRECTION: dir_r <= shift_r;
                                        default: ;
                                    endcase
                                end
                            end
                        end
                    end
                    GXP_ACK: begin
                        // Port data is latched at the ACK rising edge.
                        if (scl_rise && rd_mode_r) begin
                            tx_r <= reg_read(ptr_r, in_cap_nxt);
                            clr_pulse_r <= (ptr_r == `GXP_CMD_INPUT);
                        end
                        if (scl_fall) begin
                            ack_drive_r <= 1'b0;
                            state_r <= rd_mode_r ? GXP_RDB : GXP_WRB;
                            if (rd_mode_r) begin
                                ack_drive_r <= ~tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b0};
                                bit_cnt_r <= 4'h1;
                            end
                        end
                    end
                    GXP_RDB: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == 4'h8) begin
                                ack_drive_r <= 1'b0;
                                state_r <= GXP_RACK;
                            end else begin
                                ack_drive_r <= ~tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    GXP_RACK: begin
                        // Master ACK asks for another byte.
                        if (scl_rise) begin
                            if (sda) begin
                                state_r <= GXP_IDLE;
                            end else begin
                                state_r <= GXP_ACK;
                                tx_r <= reg_read(ptr_r, in_cap_nxt);
                                clr_pulse_r <= (ptr_r == `GXP_CMD_INPUT);
                            end
                        end
                    end
                    default: state_r <= GXP_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Input capture and interrupt
    // ------------------------------------------------------------
    // The reported value applies polarity, so comparison uses it too.
    assign in_cap_nxt = pins ^ pol_r;

    logic [7:0] diff;
    logic [12:0] iv_cnt_r;
    logic irq_r;
    // Only pins in input mode compare; outputs are masked.
    assign diff = (in_cap_nxt ^ in_cap_r) & dir_r;

    always_ff @(posedge i_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            in_cap_r <= 8'h00;
            iv_cnt_r <= 13'h0000;
            irq_r <= 1'b0;
        end else begin
            // Capture on read ACK; a change in that pulse may be lost.
            if (clr_pulse_r) begin
                in_cap_r <= in_cap_nxt;
            end
            // A return to the captured level clears by itself.
            if (diff == 8'h00 || clr_pulse_r) begin
                iv_cnt_r <= 13'h0000;
                irq_r <= 1'b0;
            end else if (iv_cnt_r ==
                         13'(`GXP_IRQ_VALID_CYC - 1)) begin
                irq_r <= 1'b1;
            end else begin
                iv_cnt_r <= iv_cnt_r + 13'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            o_port_pins <= `GXP_RST_OUTPUT;
            o_port_pins_oe <= 8'h00;
            o_irq_b <= 1'b1;
            o_irq_oe <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            o_port_pins <= out_r;
            o_port_pins_oe <= ~dir_r;
            o_irq_b <= 1'b0;
            o_irq_oe <= irq_r;
            o_sda_oe <= ack_drive_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // The counter and pointer checks catch slips that the bench only
    // sees thousands of cycles later, from outside the block.
    a_input_hiz: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        ##1 (o_port_pins_oe & $past(dir_r)) == 8'h00)
        else $error("input pin driven");
    a_irq_open: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        o_irq_oe |-> !o_irq_b)
        else $error("interrupt driven high");
    a_irq_cause: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        $rose(irq_r) |-> $past(diff) != 8'h00)
        else $error("interrupt without change");
    a_irq_clear: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        clr_pulse_r |=> !irq_r)
        else $error("read did not clear interrupt");
    a_out_ignore: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        (dir_r == 8'h00) |-> diff == 8'h00)
        else $error("output pin compared");
    a_out_drive: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        ##1 o_port_pins == $past(out_r))
        else $error("output level wrong");
    a_nack_early: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        (state_r == GXP_ACK && rd_mode_r) |-> ptr_valid_r)
        else $error("read acked without pointer");
    a_foreign_idle: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        (state_r == GXP_ADDR && scl_fall && bit_cnt_r == 4'h8 &&
         !addr_match) |=> state_r == GXP_IDLE)
        else $error("foreign address accepted");
    a_sda_idle: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        (state_r == GXP_IDLE) |-> !ack_drive_r)
        else $error("data line pulled while idle");
    a_dir_follow: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        ##1 o_port_pins_oe == ~$past(dir_r))
        else $error("direction not applied");
    a_irq_delay: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        $rose(irq_r) |-> iv_cnt_r == 13'(`GXP_IRQ_VALID_CYC - 1))
        else $error("interrupt before valid delay");
    a_irq_return: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        (diff == 8'h00) |=> !irq_r)
        else $error("interrupt kept after return");
    a_ptr_hold: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        (state_r != GXP_WRB) |=> $stable(ptr_r))
        else $error("pointer changed outside command");
    a_irq_pin: assert property (
        @(posedge i_clk) disable iff (!rst_b_r)
        ##1 o_irq_oe == $past(irq_r))
        else $error("interrupt pin does not follow");

endmodule // gxp_expander

// file: design/gxp_regs.svh
// Purpose: Constants for the eight-bit I2C port expander.
// Assumes: Included by the package and the expander core.
// Notes: Offsets are command-byte values; counts are in i_clk cycles.
//
// Overview of operation
// - Interrupt while input pin differs from capture.
// - Either edge on input pin raises interrupt.
// - Clear on return to level or port read.
// - Read clears at ACK before port byte.
// - Change during clearing ACK may be lost.
// - Every later change is detected again.
// - Outputs and foreign transfers never touch interrupt.
// - Output-to-input switch may raise false interrupt.
// - Interrupt pin only pulls low or floats.
// - Input pins drive neither high nor low.
// - Output pins drive level from output register.
// - Reset initialises registers and bus machine.
// - All pins default to input after reset.
// - One bit per pin in eight-bit registers.
// - Polarity register optionally inverts reported input.
// - All four registers readable by master.
// - Address is 0111 plus three select pins.
// - Command low bits pick input/output/polarity/direction.
// - Last command byte stays as read pointer.
// - Direction bit one means input, zero output.
// - Polarity bit one inverts, zero reports true.
`ifndef GXP_REGS_SVH
`define GXP_REGS_SVH

`define GXP_CMD_INPUT 2'h0
`define GXP_CMD_OUTPUT 2'h1
`define GXP_CMD_POLARITY 2'h2
`define GXP_CMD_DIRECTION 2'h3
`define GXP_RST_OUTPUT 8'hFF
`define GXP_RST_POLARITY 8'h00
`define GXP_RST_DIRECTION 8'hFF
`define GXP_ADDR_FIXED 4'h7
`define GXP_CLK_MHZ 250
`define GXP_IRQ_VALID_NS 4000
`define GXP_IRQ_VALID_CYC ((`GXP_IRQ_VALID_NS * `GXP_CLK_MHZ) / 1000)

`endif

// file: design/gxp_pkg.sv
// Purpose: Types for the eight-bit I2C port expander.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot.
`include "gxp_regs.svh"
package gxp_pkg;
    typedef enum logic [5:0] {
        GXP_IDLE = 6'h01,
        GXP_ADDR = 6'h02,
        GXP_ACK = 6'h04,
        GXP_WRB = 6'h08,
        GXP_RDB = 6'h10,
        GXP_RACK = 6'h20
    } gxp_state_t;
endpackage

// file: test/gxp_master_model.sv
// Purpose: Bus master model that drives SCL and SDA toward the expander.
// Assumes: Open-drain bus with pull-ups; o_sda_low high pulls SDA low.
// Notes: SCL stands high between frames, as a real master leaves it.
`timescale 1ns/1ps
module gxp_master_model (
    // Clock and bus.
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    localparam int HALF = 12;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick();
        repeat (HALF) @(posedge i_clk);
        #1;
    endtask
    // SDA moves only a few clocks after SCL falls, so the slave never
    // mistakes a data change for a start or stop.
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = ~b;
        tick();
        o_scl = 1'b1;
        tick();
        r = i_sda;
        o_scl = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic start();
        o_sda_low = 1'b0;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda_low = 1'b1;
        tick();
        o_scl = 1'b0;
        tick();
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda_low = 1'b0;
        tick();
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Address, command and an optional data byte, then stop.
    task automatic wr(input logic [7:0] a, input logic [7:0] c,
                      input logic [7:0] d, input bit has_d,
                      output logic ack);
        logic k;
        start();
        put_byte(a, ack);
        if (ack) begin
            put_byte(c, k);
            if (has_d) begin
                put_byte(d, k);
            end
        end
        stop();
    endtask
    // One byte read, ended by a NACK and a stop.
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ack);
        logic r;
        start();
        put_byte(a, ack);
        d = 8'h00;
        if (ack) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(1'b1, r);
                d[i] = r;
            end
            bit_io(1'b1, r);
        end
        stop();
    endtask
endmodule // gxp_master_model

// file: test/gxp_expander_test.sv
// Purpose: Self-checking bench for the port expander.
// Assumes: Select pins 101, so the address byte is 7A for write.
// Notes: Interrupt waits exceed the 1000-clock valid delay.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module gxp_expander_test;
    localparam logic [7:0] WA = 8'h7A;
    localparam logic [7:0] RA = 8'h7B;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] ext = 8'h00;
    logic [7:0] d;
    logic ack;
    int fail_count = 0;
    int checked = 0;
    wire scl, sda_low, sda_oe, irq_b, irq_oe;
    wire [7:0] pins, pout, poe;
    wire sda = ~(sda_low | sda_oe);
    assign pins = (poe & pout) | (~poe & ext);
    always #2 i_clk = ~i_clk;
    gxp_master_model m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));
    gxp_expander uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_addr_sel_bit0(1'b1), .i_addr_sel_bit1(1'b0),
        .i_addr_sel_bit2(1'b1), .i_scl(scl), .i_sda(sda),
        .o_sda_oe(sda_oe), .i_port_pins(pins), .o_port_pins(pout),
        .o_port_pins_oe(poe), .o_irq_b(irq_b), .o_irq_oe(irq_oe));
    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic set_reg(input logic [7:0] c, input logic [7:0] v);
        m.wr(WA, c, v, 1'b1, ack);
    endtask
    task automatic get_reg(input logic [7:0] c, output logic [7:0] v);
        m.wr(WA, c, 8'h00, 1'b0, ack);
        m.rd(RA, v, ack);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] exp_v [1:3] = '{8'hFF, 8'h00, 8'hFF};
        `CHK(poe, 8'h00)
        `CHK(pout, 8'hFF)
        m.rd(RA, d, ack);
        `CHK(ack, 1'b0)
        for (int c = 1; c <= 3; c++) begin
            get_reg(c[7:0], d);
            `CHK(d, exp_v[c])
        end
        m.wr(8'h7C, 8'h03, 8'h00, 1'b1, ack);
        `CHK(ack, 1'b0)
        `CHK(poe, 8'h00)
    endtask
    task automatic t_out();
        set_reg(8'h03, 8'hF0);
        set_reg(8'h01, 8'hA5);
        `CHK(poe, 8'h0F)
        `CHK(pout[3:0], 4'h5)
        get_reg(8'h01, d);
        `CHK(d, 8'hA5)
        m.rd(RA, d, ack);
        `CHK(d, 8'hA5)
    endtask
    task automatic t_irq();
        ext = 8'h10;
        wait_clk(1100);
        `CHK(irq_oe, 1'b1)
        `CHK(irq_b, 1'b0)
        ext = 8'h00;
        wait_clk(20);
        `CHK(irq_oe, 1'b0)
        ext = 8'h10;
        wait_clk(1100);
        `CHK(irq_oe, 1'b1)
        m.wr(8'h40, 8'h01, 8'h00, 1'b1, ack);
        `CHK(irq_oe, 1'b1)
        get_reg(8'h00, d);
        `CHK(d, 8'h15)
        `CHK(irq_oe, 1'b0)
        set_reg(8'h01, 8'h0A);
        wait_clk(1100);
        `CHK(irq_oe, 1'b0)
    endtask
    task automatic t_pol();
        set_reg(8'h02, 8'hF0);
        get_reg(8'h00, d);
        `CHK(d, 8'hEA)
        set_reg(8'h02, 8'h00);
        get_reg(8'h00, d);
        `CHK(d, 8'h1A)
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------
    initial begin
        wait_clk(12);
        i_rst_b = 1'b1;
        wait_clk(8);
        t_reset();
        t_out();
        t_irq();
        t_pol();
        close_out();
    end
    initial begin
        #400000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
endmodule // gxp_expander_test
